// *** verilog/fhm_pkg.sv ***
/*
  Constants and types for the framer host and monitor I/O block.
  Assumes a single 125 MHz system clock; all pins are sampled on it.
*/
package fhm_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADR_LINK_CTRL = 8'h00;
  localparam logic [7:0] ADR_IRQ_EN = 8'h02;
  localparam logic [7:0] ADR_FEATURE = 8'h04;
  localparam logic [7:0] ADR_PAYLOAD_PARALLEL_LINK_CTRL = 8'h05;
  localparam logic [7:0] ADR_CNT_STAT = 8'h11;
  localparam logic [7:0] ADR_LINK_STAT = 8'h12;
  localparam logic [7:0] ADR_CNT_BASE = 8'h20;

  // ==========================================================
  // Field positions and reset values
  localparam int LINK_EN_BIT = 0;
  localparam int PAR_EN_BIT = 3;
  localparam int NIBBLE_BIT = 0;
  localparam int TRANSP_BIT = 1;
  localparam int FCS32_BIT = 2;
  localparam int ALARM_LSB = 4;
  localparam int ALARM_MSB = 6;
  localparam int CBIT_EXT_BIT = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ==========================================================
  // Maintenance counters: 0 lcv, 1 frame error, 2 parity, 3 far_end_block_error, 4 x-bit
  localparam int NUM_CNT = 5;
  localparam logic [4:0] DS3_ONLY_CNT = 5'h1d;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_RST = 8'h00;

  // Monitor byte when monitor operation is not allowed (bit 6 is active low)
  localparam logic [7:0] MON_QUIET = 8'h40;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int INIT_MIN_NS = 200;
  localparam logic [4:0] INIT_CYC =
    5'((INIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ADDR = 2'b01,
    BUS_DATA = 2'b11
  } fhm_bus_st_t;
endpackage : fhm_pkg

// *** verilog/fhm_sync.sv ***
/*
  Two-flop synchroniser for a vector of unrelated pin levels.
  Assumes each bit is an independent level, not a coded word.
*/
`timescale 1ns/1ps
module fhm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  always_comb begin
    next_meta = i_async;
    next_sync = meta;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      meta <= RST;
      o_sync <= RST;
    end else begin
      meta <= next_meta;
      o_sync <= next_sync;
    end
  end
endmodule : fhm_sync

// *** verilog/fhm_bus.sv ***
/*
  Slave for the 8-bit multiplexed address/data host bus.
  Assumes all bus pins arrive already synchronised to i_clk_sys.
*/
`timescale 1ns/1ps
module fhm_bus (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_cs,
  input wire logic [7:0] i_ad,
  input wire logic i_block,
  input wire logic [7:0] i_rd_data,
  output logic o_wr_stb,
  output logic [7:0] o_addr,
  output logic [7:0] o_wr_data,
  output logic [7:0] o_ad,
  output logic o_ad_oe
);
  fhm_pkg::fhm_bus_st_t st, next_st;
  logic wr_n_d, next_wr_n_d;
  logic next_wr_stb;
  logic [7:0] next_addr, next_wr_data, next_ad;
  logic next_ad_oe;

  // ==========================================================
  // Address latch, write on strobe release, read drive
  always_comb begin
    next_st = st;
    next_addr = o_addr;
    next_wr_data = o_wr_data;
    next_wr_n_d = i_wr_n;
    next_wr_stb = 1'b0;
    next_ad = i_rd_data;
    next_ad_oe = 1'b0;
    case (st)
      fhm_pkg::BUS_IDLE: begin
        if (i_ale) begin
          next_st = fhm_pkg::BUS_ADDR;
        end
      end
      fhm_pkg::BUS_ADDR: begin
        // Latch only while ALE is high; the data phase starts the cycle after its fall
        if (i_ale) begin
          next_addr = i_ad;
        end else begin
          next_st = fhm_pkg::BUS_DATA;
        end
      end
      fhm_pkg::BUS_DATA: begin
        if (i_ale) begin
          next_st = fhm_pkg::BUS_ADDR;
        end
        // Accesses need chip select high and no initialisation
        if (i_cs && !i_block) begin
          if (!i_wr_n) begin
            next_wr_data = i_ad;
          end
          next_wr_stb = i_wr_n && !wr_n_d;
          next_ad_oe = !i_rd_n && i_wr_n;
        end
      end
      default: next_st = fhm_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st <= fhm_pkg::BUS_IDLE;
      o_addr <= 8'h00;
      o_wr_data <= 8'h00;
      wr_n_d <= 1'b1;
      o_wr_stb <= 1'b0;
      o_ad <= 8'h00;
      o_ad_oe <= 1'b0;
    end else begin
      st <= next_st;
      o_addr <= next_addr;
      o_wr_data <= next_wr_data;
      wr_n_d <= next_wr_n_d;
      o_wr_stb <= next_wr_stb;
      o_ad <= next_ad;
      o_ad_oe <= next_ad_oe;
    end
  end

  a_cs_write: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_wr_stb |-> $past(i_cs) && !$past(i_block))
    else $error("bus write taken without chip select");
endmodule : fhm_bus

// *** verilog/fhm_io.sv ***
/*
  Host and monitor I/O of the framer: shared receive byte / monitor pins,
  dual-use carry and checksum pins, maintenance counters, initialisation,
  transmit clock edge sampling and the multiplexed host bus with interrupts.
  Assumes framer core signals arrive on i_clk_sys; pins are synchronised here.
*/
`timescale 1ns/1ps
// Functional notes
// - Bits 3,4: idle code, frame error flags
// - Bit 5: violation counter overflow carry pulse
// - Bit 6: low during receive overhead bits
// - Bit 7: unencoded transmit data copy
// - Idle after non-idle, else frame carry
// - Good checksum, else low transmit overhead
// - Phase control valid only with buffer on
// - Stand-alone monitor only in DS3 mode
// - Parallel select: register bit or pin
// - Receiver byte, nibble or transparent modes
// - Buffer on: read with dejittered clock
// - Buffer off: raw clock, dejittered grounded
// - Transmit FCS 16 or 32, unformatted
// - Transmit alarms and external overhead bits
// - Data link: C-bits or E3 N-bit
// - Serial on falling, sync on rising
// - Init low 200 ns clears counters
// - Multiplexed 8-bit bus like static RAM
// - Two active-low interrupts: link, counters
// - DS3-only detection and counting
// - Chip select high enables accesses
// - Bits 0-2: loss, out-of-frame, AIS
module fhm_io (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_host_mode_select,
  input wire logic i_latch_enable_or_parallel_select,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_chip_select_in,
  input wire logic [7:0] i_ad,
  input wire logic i_init_n,
  input wire logic i_dejitter_buffer_enable,
  input wire logic i_transmit_clock_in,
  input wire logic i_transmit_serial_in,
  input wire logic i_transmit_frame_sync_in,
  input wire logic i_ds3_mode,
  input wire logic [7:0] i_payload_parallel_link_byte,
  input wire logic i_los,
  input wire logic i_oof,
  input wire logic i_ais,
  input wire logic i_idle_code,
  input wire logic i_frame_error,
  input wire logic i_line_code_violation,
  input wire logic i_parity_error,
  input wire logic i_far_end_block_error,
  input wire logic i_xbit_disagree,
  input wire logic i_rx_overhead,
  input wire logic i_tx_nrz,
  input wire logic i_tx_overhead,
  input wire logic i_hdlc_flag,
  input wire logic i_hdlc_octet,
  input wire logic i_fcs_good,
  input wire logic i_fifo_phase,
  output logic [7:0] o_receive_parallel_byte,
  output logic o_idle_frame_carry,
  output logic o_good_checksum_flag,
  output logic o_vco_phase,
  output logic o_link_irq_n,
  output logic o_counter_irq_n,
  output logic [7:0] o_ad,
  output logic o_ad_oe,
  output logic o_rx_clock_dejittered,
  output logic o_tx_serial_bit,
  output logic o_tx_frame_sync,
  output logic o_payload_parallel_link_nibble,
  output logic o_payload_parallel_link_transparent,
  output logic o_fcs32_select,
  output logic [2:0] o_tx_alarm_code,
  output logic o_tx_cbit_external,
  output logic o_tdl_use_nbit
);
  // ==========================================================
  // Pin synchronisers
  logic s_host, s_ale, s_rd_n, s_wr_n, s_cs, s_init_n, s_fifo_en;
  logic s_txck, s_txdat, s_txsync;
  logic [7:0] s_ad;

  fhm_sync #(.W(18), .RST(18'h0c010)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async({i_host_mode_select, i_latch_enable_or_parallel_select, i_rd_n,
      i_wr_n, i_chip_select_in, i_ad, i_init_n, i_dejitter_buffer_enable,
      i_transmit_clock_in, i_transmit_serial_in, i_transmit_frame_sync_in}),
    .o_sync({s_host, s_ale, s_rd_n, s_wr_n, s_cs, s_ad, s_init_n, s_fifo_en,
      s_txck, s_txdat, s_txsync})
  );

  // ==========================================================
  // Initialisation: clear counters once low long enough
  logic [4:0] init_cnt, next_init_cnt;
  logic cnt_clear;

  always_comb begin
    next_init_cnt = 5'h00;
    if (!s_init_n) begin
      next_init_cnt = (init_cnt == fhm_pkg::INIT_CYC) ? init_cnt : init_cnt + 5'h01;
    end
    cnt_clear = !s_init_n && (init_cnt == fhm_pkg::INIT_CYC);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      init_cnt <= 5'h00;
    end else begin
      init_cnt <= next_init_cnt;
    end
  end

  // ==========================================================
  // Host bus
  logic wr_stb;
  logic [7:0] bus_addr, wr_data, rd_data;

  fhm_bus u_bus (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_ale(s_ale),
    .i_rd_n(s_rd_n),
    .i_wr_n(s_wr_n),
    .i_cs(s_cs),
    .i_ad(s_ad),
    .i_block(s_host || !s_init_n),
    .i_rd_data(rd_data),
    .o_wr_stb(wr_stb),
    .o_addr(bus_addr),
    .o_wr_data(wr_data),
    .o_ad(o_ad),
    .o_ad_oe(o_ad_oe)
  );

  // ==========================================================
  // Maintenance counters with ripple carries
  logic [4:0] ev, ev_gated, carry;
  logic [7:0] cnt [fhm_pkg::NUM_CNT];

  assign ev = {i_xbit_disagree, i_far_end_block_error, i_parity_error,
    i_frame_error, i_line_code_violation};
  assign ev_gated = ev & (i_ds3_mode ? 5'h1f : ~fhm_pkg::DS3_ONLY_CNT);

  for (genvar g = 0; g < fhm_pkg::NUM_CNT; g++) begin : g_cnt
    logic [7:0] next_cnt;
    logic next_carry;
    always_comb begin
      next_cnt = cnt[g];
      next_carry = 1'b0;
      if (cnt_clear) begin
        next_cnt = fhm_pkg::CNT_RST;
      end else if (ev_gated[g]) begin
        next_cnt = cnt[g] + 8'h01;
        next_carry = (cnt[g] == fhm_pkg::CNT_MAX);
      end
    end
    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
        cnt[g] <= fhm_pkg::CNT_RST;
        carry[g] <= 1'b0;
      end else begin
        cnt[g] <= next_cnt;
        carry[g] <= next_carry;
      end
    end
  end

  // ==========================================================
  // Registers and sticky status
  logic [7:0] link_ctrl, irq_en, feature, payload_parallel_link_ctrl;
  logic [7:0] next_link_ctrl, next_irq_en, next_feature, next_payload_parallel_link_ctrl;
  logic [4:0] cnt_stat, next_cnt_stat;
  logic [1:0] link_stat, next_link_stat;
  logic seen_nonidle, next_seen_nonidle;
  logic idle_event;

  assign idle_event = i_hdlc_flag && seen_nonidle;

  always_comb begin
    next_link_ctrl = link_ctrl;
    next_irq_en = irq_en;
    next_feature = feature;
    next_payload_parallel_link_ctrl = payload_parallel_link_ctrl;
    next_cnt_stat = cnt_stat;
    next_link_stat = link_stat;
    next_seen_nonidle = seen_nonidle;
    if (i_hdlc_octet) begin
      next_seen_nonidle = 1'b1;
    end else if (i_hdlc_flag) begin
      next_seen_nonidle = 1'b0;
    end
    if (wr_stb) begin
      case (bus_addr)
        fhm_pkg::ADR_LINK_CTRL: next_link_ctrl = wr_data;
        fhm_pkg::ADR_IRQ_EN: next_irq_en = wr_data;
        fhm_pkg::ADR_FEATURE: next_feature = wr_data;
        fhm_pkg::ADR_PAYLOAD_PARALLEL_LINK_CTRL: next_payload_parallel_link_ctrl = wr_data;
        fhm_pkg::ADR_CNT_STAT: next_cnt_stat = cnt_stat & ~wr_data[4:0];
        fhm_pkg::ADR_LINK_STAT: next_link_stat = link_stat & ~wr_data[1:0];
        default: next_link_ctrl = link_ctrl;
      endcase
    end
    // Set wins over a clear in the same cycle
    next_cnt_stat = next_cnt_stat | carry;
    next_link_stat = next_link_stat | {i_fcs_good, idle_event};
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      link_ctrl <= fhm_pkg::CTRL_RST;
      irq_en <= fhm_pkg::CTRL_RST;
      feature <= fhm_pkg::CTRL_RST;
      payload_parallel_link_ctrl <= fhm_pkg::CTRL_RST;
      cnt_stat <= 5'h00;
      link_stat <= 2'h0;
      seen_nonidle <= 1'b0;
    end else begin
      link_ctrl <= next_link_ctrl;
      irq_en <= next_irq_en;
      feature <= next_feature;
      payload_parallel_link_ctrl <= next_payload_parallel_link_ctrl;
      cnt_stat <= next_cnt_stat;
      link_stat <= next_link_stat;
      seen_nonidle <= next_seen_nonidle;
    end
  end

  // Read data; unmapped offsets read zero
  always_comb begin
    rd_data = 8'h00;
    case (bus_addr)
      fhm_pkg::ADR_LINK_CTRL: rd_data = link_ctrl;
      fhm_pkg::ADR_IRQ_EN: rd_data = irq_en;
      fhm_pkg::ADR_FEATURE: rd_data = feature;
      fhm_pkg::ADR_PAYLOAD_PARALLEL_LINK_CTRL: rd_data = payload_parallel_link_ctrl;
      fhm_pkg::ADR_CNT_STAT: rd_data = {3'h0, cnt_stat};
      fhm_pkg::ADR_LINK_STAT: rd_data = {6'h00, link_stat};
      default: begin
        if (bus_addr[7:3] == fhm_pkg::ADR_CNT_BASE[7:3] && bus_addr[2:0] < 3'h5) begin
          rd_data = cnt[bus_addr[2:0]];
        end
      end
    endcase
  end

  // ==========================================================
  // Pin outputs, all registered on the system clock i_clk_sys
  logic par_mode, quiet, txck_d, tx_fall, tx_rise;
  logic [7:0] next_byte;
  logic next_idle_carry, next_fcs, next_vco, next_link_irq_n, next_cnt_irq_n;
  logic next_txbit, next_txsync;

  always_comb begin
    par_mode = s_host ? s_ale : feature[fhm_pkg::PAR_EN_BIT];
    quiet = s_host && !i_ds3_mode && !par_mode;
    tx_fall = txck_d && !s_txck;
    tx_rise = !txck_d && s_txck;
    if (par_mode) begin
      next_byte = i_payload_parallel_link_byte;
    end else if (quiet) begin
      next_byte = fhm_pkg::MON_QUIET;
    end else begin
      next_byte = {i_tx_nrz,
        !i_rx_overhead,
        carry[0],
        i_frame_error, i_idle_code,
        i_ais, i_oof, i_los};
    end
    next_idle_carry = par_mode ? idle_event : carry[1];
    next_fcs = par_mode ? i_fcs_good : !i_tx_overhead;
    next_vco = s_fifo_en && i_fifo_phase;
    next_link_irq_n = !(link_ctrl[fhm_pkg::LINK_EN_BIT] && |link_stat);
    next_cnt_irq_n = !(|(cnt_stat & irq_en[4:0]));
    next_txbit = tx_fall ? s_txdat : o_tx_serial_bit;
    next_txsync = tx_rise ? s_txsync : o_tx_frame_sync;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_receive_parallel_byte <= 8'h00;
      o_idle_frame_carry <= 1'b0;
      o_good_checksum_flag <= 1'b0;
      o_vco_phase <= 1'b0;
      o_link_irq_n <= 1'b1;
      o_counter_irq_n <= 1'b1;
      o_rx_clock_dejittered <= 1'b0;
      o_tx_serial_bit <= 1'b0;
      o_tx_frame_sync <= 1'b0;
      txck_d <= 1'b0;
      o_tdl_use_nbit <= 1'b0;
    end else begin
      o_receive_parallel_byte <= next_byte;
      o_idle_frame_carry <= next_idle_carry;
      o_good_checksum_flag <= next_fcs;
      o_vco_phase <= next_vco;
      o_link_irq_n <= next_link_irq_n;
      o_counter_irq_n <= next_cnt_irq_n;
      o_rx_clock_dejittered <= s_fifo_en;
      o_tx_serial_bit <= next_txbit;
      o_tx_frame_sync <= next_txsync;
      txck_d <= s_txck;
      o_tdl_use_nbit <= !i_ds3_mode;
    end
  end

  // Transmit and receiver configuration straight from control registers
  assign o_payload_parallel_link_nibble = payload_parallel_link_ctrl[fhm_pkg::NIBBLE_BIT];
  assign o_payload_parallel_link_transparent = payload_parallel_link_ctrl[fhm_pkg::TRANSP_BIT];
  assign o_fcs32_select = payload_parallel_link_ctrl[fhm_pkg::FCS32_BIT];
  assign o_tx_alarm_code = payload_parallel_link_ctrl[fhm_pkg::ALARM_MSB:fhm_pkg::ALARM_LSB];
  assign o_tx_cbit_external = payload_parallel_link_ctrl[fhm_pkg::CBIT_EXT_BIT];

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  a_mon_idle_frm: assert property (
    !par_mode && !quiet |=> o_receive_parallel_byte[4:3] == $past({i_frame_error, i_idle_code}))
    else $error("monitor idle or frame error bit wrong");
  a_lcv_carry_out: assert property (
    !par_mode && !quiet && carry[0] |=> o_receive_parallel_byte[5])
    else $error("violation carry not on monitor bit 5");
  a_rx_ovh_low: assert property (
    !par_mode && !quiet && i_rx_overhead |=> !o_receive_parallel_byte[6])
    else $error("receive overhead marker not low");
  a_idle_carry: assert property (
    par_mode && i_hdlc_flag && !i_hdlc_octet && seen_nonidle |=> o_idle_frame_carry && !seen_nonidle)
    else $error("idle after non-idle not reported");
  a_fcs_dual: assert property (
    !par_mode && i_tx_overhead |=> !o_good_checksum_flag)
    else $error("transmit overhead marker not low");
  a_vco_gate: assert property (
    !s_fifo_en |=> !o_vco_phase)
    else $error("phase control active with buffer off");
  a_e3_quiet: assert property (
    quiet |=> o_receive_parallel_byte == fhm_pkg::MON_QUIET)
    else $error("monitor active in E3 stand-alone");
  a_init_clear: assert property (
    !s_init_n && init_cnt == fhm_pkg::INIT_CYC |=> cnt[0] == 8'h00 && cnt[1] == 8'h00)
    else $error("counters not cleared by init");
  a_e3_no_lcv: assert property (
    !i_ds3_mode && !cnt_clear |=> cnt[0] == $past(cnt[0]))
    else $error("violation counted in E3 mode");
  a_link_irq_off: assert property (
    !link_ctrl[fhm_pkg::LINK_EN_BIT] |=> o_link_irq_n)
    else $error("link interrupt active while disabled");
endmodule : fhm_io

// *** verif/fhm_host_model.sv ***
/*
  Microcontroller model driving the multiplexed address/data host bus.
  Assumes the bench resolves the shared AD wire and feeds it back on i_ad.
*/
`timescale 1ns/1ps
module fhm_host_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_ad,
  input wire logic i_ad_oe,
  output logic o_ale,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_cs,
  output logic [7:0] o_ad
);
  // ==========================================================
  // Bus cycles
  initial begin
    o_ale = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_cs = 1'b0;
    o_ad = 8'h00;
  end

  // Address latched while ale high, then one quiet cycle
  task automatic addr_phase(input logic [7:0] a, input logic cs);
    @(posedge i_clk_sys);
    o_cs <= cs;
    o_ale <= 1'b1;
    o_ad <= a;
    repeat (3) @(posedge i_clk_sys);
    o_ale <= 1'b0;
    @(posedge i_clk_sys);
  endtask : addr_phase

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic cs);
    addr_phase(a, cs);
    o_ad <= d;
    o_wr_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    o_wr_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    o_cs <= 1'b0;
    o_ad <= ~d;
    repeat (3) @(posedge i_clk_sys);
  endtask : wr

  // Released data lines show the inverse of the last value driven
  // Write strobe stays high through a read, as an R/W-line host does
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    addr_phase(a, 1'b1);
    o_ad <= ~a;
    o_rd_n <= 1'b0;
    for (n = 0; n < 12 && i_ad_oe !== 1'b1; n++) begin
      @(posedge i_clk_sys);
    end
    d = i_ad;
    o_rd_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    o_cs <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
  endtask : rd
endmodule : fhm_host_model

// *** verif/framer_host_monitor_io_tb_top.sv ***
/*
  Self-checking bench for the framer host and monitor I/O block.
  Assumes a 125 MHz system clock and the host model on the bus pins.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; $display("FAIL t=%0t got %h exp %h", $time, (a), (e)); end end
module framer_host_monitor_io_tb_top;
  // ==========================================================
  // Signals
  logic i_clk_sys = 0, i_sys_rst = 1, i_host_mode_select = 1, par_pin = 0, i_init_n = 1;
  logic i_dejitter_buffer_enable = 0, i_transmit_clock_in = 0, i_transmit_serial_in = 0;
  logic i_transmit_frame_sync_in = 0, i_ds3_mode = 1, i_los = 0, i_oof = 0, i_ais = 0;
  logic i_idle_code = 0, i_frame_error = 0, i_line_code_violation = 0, i_parity_error = 0;
  logic i_far_end_block_error = 0, i_xbit_disagree = 0, i_rx_overhead = 0, i_tx_nrz = 0;
  logic i_tx_overhead = 0, i_hdlc_flag = 0, i_hdlc_octet = 0, i_fcs_good = 0, i_fifo_phase = 0;
  logic [7:0] i_payload_parallel_link_byte = 8'h00, o_receive_parallel_byte, o_ad, h_ad, d;
  logic o_idle_frame_carry, o_good_checksum_flag, o_vco_phase, o_link_irq_n, o_counter_irq_n;
  logic o_ad_oe, o_rx_clock_dejittered, o_tx_serial_bit, o_tx_frame_sync, o_payload_parallel_link_nibble;
  logic o_payload_parallel_link_transparent, o_fcs32_select, o_tx_cbit_external, o_tdl_use_nbit, h_ale;
  logic [2:0] o_tx_alarm_code;
  wire i_rd_n, i_wr_n, i_chip_select_in;
  wire [7:0] i_ad = o_ad_oe ? o_ad : h_ad;
  wire i_latch_enable_or_parallel_select = i_host_mode_select ? par_pin : h_ale;
  int n_errors = 0, checks = 0, cyc = 0, n_lcv = 0, n_frm = 0, n_fcs = 0;

  always #4 i_clk_sys = ~i_clk_sys;

  fhm_io dut (.*);

  fhm_host_model h (.i_clk_sys(i_clk_sys), .i_ad(i_ad), .i_ad_oe(o_ad_oe), .o_ale(h_ale),
    .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_cs(i_chip_select_in), .o_ad(h_ad));

  // ==========================================================
  // Pulse counters and timeout
  always @(posedge i_clk_sys) begin
    cyc++;
    n_lcv += int'(o_receive_parallel_byte[5] === 1'b1);
    n_frm += int'(o_idle_frame_carry === 1'b1);
    n_fcs += int'(o_good_checksum_flag === 1'b1);
    if (cyc == 8000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic do_reset;
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
  endtask : do_reset

  task automatic pulse_ev(input int n);
    @(posedge i_clk_sys);
    i_line_code_violation <= 1'b1;
    i_frame_error <= 1'b1;
    repeat (n) @(posedge i_clk_sys);
    i_line_code_violation <= 1'b0;
    i_frame_error <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
  endtask : pulse_ev

  // ==========================================================
  // Scenarios
  task automatic t_monitor;
    @(posedge i_clk_sys);
    {i_tx_nrz, i_rx_overhead, i_frame_error, i_idle_code, i_ais, i_oof, i_los} <= 7'h7f;
    i_tx_overhead <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    `CHK(o_receive_parallel_byte, 8'h9f)
    `CHK(o_good_checksum_flag, 1'b0)
    {i_tx_nrz, i_rx_overhead, i_frame_error, i_idle_code, i_ais, i_oof, i_los} <= 7'h44;
    i_tx_overhead <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    `CHK(o_receive_parallel_byte, 8'hc4)
    `CHK(o_good_checksum_flag, 1'b1)
    i_tx_nrz <= 1'b0;
    i_ais <= 1'b0;
  endtask : t_monitor

  // No bus traffic while init is low
  task automatic t_carry;
    pulse_ev(200);
    i_init_n <= 1'b0;
    repeat (30) @(posedge i_clk_sys);
    i_init_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    n_lcv = 0;
    n_frm = 0;
    pulse_ev(255);
    `CHK(n_lcv, 0)
    `CHK(n_frm, 0)
    pulse_ev(1);
    `CHK(n_lcv, 1)
    `CHK(n_frm, 1)
  endtask : t_carry

  task automatic t_tx;
    i_transmit_clock_in <= 1'b1;
    i_transmit_serial_in <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    i_transmit_clock_in <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_transmit_serial_in <= 1'b0;
    i_transmit_frame_sync_in <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    `CHK(o_tx_serial_bit, 1'b1)
    `CHK(o_tx_frame_sync, 1'b0)
    i_transmit_clock_in <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    i_transmit_frame_sync_in <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    `CHK(o_tx_frame_sync, 1'b1)
    `CHK(o_tx_serial_bit, 1'b1)
  endtask : t_tx

  task automatic t_fifo;
    i_dejitter_buffer_enable <= 1'b1;
    i_fifo_phase <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    `CHK(o_rx_clock_dejittered, 1'b1)
    `CHK(o_vco_phase, 1'b1)
    i_fifo_phase <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    `CHK(o_vco_phase, 1'b0)
    i_dejitter_buffer_enable <= 1'b0;
    i_fifo_phase <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    `CHK(o_rx_clock_dejittered, 1'b0)
    `CHK(o_vco_phase, 1'b0)
    i_fifo_phase <= 1'b0;
  endtask : t_fifo

  task automatic t_par;
    par_pin <= 1'b1;
    i_payload_parallel_link_byte <= 8'ha5;
    repeat (5) @(posedge i_clk_sys);
    `CHK(o_receive_parallel_byte, 8'ha5)
    n_frm = 0;
    n_fcs = 0;
    i_hdlc_octet <= 1'b1;
    @(posedge i_clk_sys);
    i_hdlc_octet <= 1'b0;
    i_hdlc_flag <= 1'b1;
    @(posedge i_clk_sys);
    i_fcs_good <= 1'b1;
    @(posedge i_clk_sys);
    i_fcs_good <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_hdlc_flag <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    `CHK(n_frm, 1)
    `CHK(n_fcs, 1)
    par_pin <= 1'b0;
  endtask : t_par

  task automatic t_e3;
    i_ds3_mode <= 1'b0;
    i_los <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    `CHK(o_receive_parallel_byte, fhm_pkg::MON_QUIET)
    `CHK(o_tdl_use_nbit, 1'b1)
    i_ds3_mode <= 1'b1;
    i_los <= 1'b0;
  endtask : t_e3

  task automatic t_host;
    h.wr(fhm_pkg::ADR_FEATURE, 8'h08, 1'b1);
    h.rd(fhm_pkg::ADR_FEATURE, d);
    `CHK(d, 8'h08)
    i_payload_parallel_link_byte <= 8'h3c;
    repeat (3) @(posedge i_clk_sys);
    `CHK(o_receive_parallel_byte, 8'h3c)
    h.wr(fhm_pkg::ADR_PAYLOAD_PARALLEL_LINK_CTRL, 8'hff, 1'b0);
    h.rd(fhm_pkg::ADR_PAYLOAD_PARALLEL_LINK_CTRL, d);
    `CHK(d, 8'h00)
    h.wr(fhm_pkg::ADR_PAYLOAD_PARALLEL_LINK_CTRL, 8'h76, 1'b1);
    `CHK({o_tx_cbit_external, o_tx_alarm_code, o_fcs32_select, o_payload_parallel_link_transparent, o_payload_parallel_link_nibble}, 7'h3e)
    h.wr(fhm_pkg::ADR_PAYLOAD_PARALLEL_LINK_CTRL, 8'h89, 1'b1);
    `CHK({o_tx_cbit_external, o_tx_alarm_code, o_fcs32_select, o_payload_parallel_link_transparent, o_payload_parallel_link_nibble}, 7'h41)
    h.rd(8'h3f, d);
    `CHK(d, 8'h00)
    h.wr(fhm_pkg::ADR_FEATURE, 8'h00, 1'b1);
    h.wr(fhm_pkg::ADR_IRQ_EN, 8'h01, 1'b1);
    pulse_ev(256);
    `CHK(o_counter_irq_n, 1'b0)
    `CHK(o_link_irq_n, 1'b1)
    h.rd(fhm_pkg::ADR_CNT_STAT, d);
    `CHK(d[0], 1'b1)
    h.wr(fhm_pkg::ADR_CNT_STAT, 8'h01, 1'b1);
    `CHK(o_counter_irq_n, 1'b1)
    pulse_ev(3);
    h.rd(fhm_pkg::ADR_CNT_BASE, d);
    `CHK(d, 8'h03)
    h.wr(fhm_pkg::ADR_LINK_CTRL, 8'h01, 1'b1);
    `CHK(o_link_irq_n, 1'b1)
    i_fcs_good <= 1'b1;
    @(posedge i_clk_sys);
    i_fcs_good <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    `CHK(o_link_irq_n, 1'b0)
  endtask : t_host

  // ==========================================================
  // Main sequence
  initial begin
    do_reset();
    t_monitor();
    t_carry();
    t_tx();
    t_fifo();
    t_par();
    t_e3();
    i_host_mode_select <= 1'b0;
    do_reset();
    t_host();
    end_of_test();
  end
endmodule : framer_host_monitor_io_tb_top
